// ---- failsafe_consts.svh ----
// What this block does
// - Boost overvoltage persisting 72-80us forces OFF
// - Seventeen separate cause latches incl. listed ones
// - Latches set entering OFF or on rejected wake, cleared on battery loss or copy
// - After POR and download copy latches, clear
// - Restart inhibit kept over resets, cleared by battery loss or clear command
// - Inhibit set by command with data 0xAA or regulator overvoltage
// - Inhibit cleared by command with data 0x55
// - Inhibit already set at an OFF condition: restart needs wake low then high
// - INIT clock/overvoltage fault: hold POR, timeout flag
// - Clean INIT moves to RESET on POR release
// - Clock fault or overvoltage after POR forces OFF
// - Six states: four operating, two nonoperating
// - Leave-diagnostic bit 0, timeout mask bit 1
// - RESET to SAFE keeps fault counter unchanged
// - RESET conditions outrank SAFE; SAFE after RESET clears
// - Shutdown command or any OFF condition enters OFF
// - Wake proceeds only with supply ok, no overtemperature
// - OFF drives reset and enable outputs low
// - Wake deglitched over DEGLITCH_CYC low-power clock ticks, 6500 by default
`ifndef FAILSAFE_CONSTS_SVH
`define FAILSAFE_CONSTS_SVH
`define CLK_MHZ 50
`define BOOST_OV_MIN_NS 72000
`define BOOST_OV_CYC ((`BOOST_OV_MIN_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_DEGLITCH_NS 130000
`define WAKE_DEGLITCH_CYC ((`WAKE_DEGLITCH_NS * `CLK_MHZ) / 1000)
`define STARTUP_TO_CYC 20000
`define DOWNLOAD_CYC 16
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_OFF_CAUSE 12'h008
`define ADDR_SAFETY_CHECK 12'h00c
`define ADDR_CMD 12'h010
`define ADDR_FAULT_CNT 12'h014
`define CMD_SET_INHIBIT 8'h01
`define CMD_CLR_INHIBIT 8'h02
`define CMD_SHUTDOWN 8'h03
`define DATA_SET_INHIBIT 8'haa
`define DATA_CLR_INHIBIT 8'h55
`define BIT_LEAVE_DIAG 0
`define BIT_DIAG_MASK 1
`define CAUSE_CLK 1
`define CAUSE_RST_TO 2
`define CAUSE_BOOST_OV 11
`define CAUSE_VREG_UV 12
`define CAUSE_VREG_OV 13
`define CAUSE_SUPPLY_OVERVOLTAGE_FLAG 14
`define CAUSE_DEV_ERR 15
`define CAUSE_STARTUP_TO 16
`define CAUSE_VIN_UV 0
`define CAUSE_EEPROM 3
`define CAUSE_OVERTEMP 4
`define NUM_CAUSES 17
`endif

// ---- failsafe_pkg.sv ----
package failsafe_pkg;
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_INIT = 6'h02,
    ST_RESET = 6'h04,
    ST_DIAG = 6'h08,
    ST_ACTIVE = 6'h10,
    ST_SAFE = 6'h20
  } fs_state_t;

  typedef struct packed {
    logic clockFault;
    logic vinOv;
    logic vinUv;
    logic overTemp;
    logic boostOv;
    logic vregUv;
    logic vregOv;
    logic devErrDown;
    logic eepromCrcErr;
    logic resetTimeout;
    logic resetCond;
    logic safeCond;
    logic diagDone;
  } fault_in_t;
endpackage

// ---- failsafe_off_init_controller.sv ----
`include "failsafe_consts.svh"

module failsafe_off_init_controller
  import failsafe_pkg::*;
#(
  parameter int STARTUP_TO_CYC = `STARTUP_TO_CYC,
  parameter int DEGLITCH_CYC = `WAKE_DEGLITCH_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Supply and pins
  input wire logic batteryPresent,
  input wire logic wakePin,
  input wire logic lpTick,
  input wire fault_in_t faultIn,
  input wire logic downloadDone,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device outputs
  output logic internalPorN,
  output logic systemResetOutN,
  output logic enableDriveIrqOut,
  output logic [5:0] stateOut
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] wakeSync_q;
  logic [1:0] battSync_q;
  logic [1:0] tickSync_q;
  logic tickPrev_q;
  fault_in_t fMeta_q;
  fault_in_t f_q;

  always_ff @(posedge clk)
  begin
    wakeSync_q <= {wakeSync_q[0], wakePin};
    battSync_q <= {battSync_q[0], batteryPresent};
    tickSync_q <= {tickSync_q[0], lpTick};
    tickPrev_q <= tickSync_q[1];
  end

  always_ff @(posedge clk)
  begin
    fMeta_q <= faultIn;
    f_q <= fMeta_q;
  end

  logic wake;
  logic batt;
  logic lpEn;
  assign wake = wakeSync_q[1];
  assign batt = battSync_q[1];
  assign lpEn = tickSync_q[1] & ~tickPrev_q;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = hit(a, `ADDR_CTRL) || hit(a, `ADDR_STATUS) || hit(a, `ADDR_OFF_CAUSE)
      || hit(a, `ADDR_SAFETY_CHECK) || hit(a, `ADDR_CMD) || hit(a, `ADDR_FAULT_CNT);
  endfunction

  function automatic logic isOperating(input fs_state_t s);
    isOperating = (s != ST_OFF) && (s != ST_INIT);
  endfunction

  // ---------------------------------------------------------------
  // State and working registers
  // ---------------------------------------------------------------
  fs_state_t state_q;
  fs_state_t state_d;
  logic [16:0] causeLatch_q;
  logic [16:0] offCause_q;
  logic inhibit_q;
  logic armed_q;
  logic wakeLatch_q;
  logic [15:0] deglitch_q;
  logic [31:0] initTimer_q;
  logic [11:0] boostCnt_q;
  logic copied_q;
  logic [1:0] safetyCheck_q;
  logic [3:0] faultCnt_q;
  logic shutdownCmd;
  logic setInhibitCmd;
  logic clrInhibitCmd;
  logic boostPersist;
  logic offCond;
  logic [16:0] offCauses;
  logic initFault;
  logic startupTo;
  logic apbWr;
  logic wakeReject;
  logic copyNow;

  assign apbWr = psel & penable & pwrite & pready;
  assign shutdownCmd = apbWr & hit(paddr, `ADDR_CMD) & (pwdata[15:8] == `CMD_SHUTDOWN);
  assign setInhibitCmd = apbWr & hit(paddr, `ADDR_CMD) & (pwdata[15:8] == `CMD_SET_INHIBIT)
    & (pwdata[7:0] == `DATA_SET_INHIBIT);
  assign clrInhibitCmd = apbWr & hit(paddr, `ADDR_CMD) & (pwdata[15:8] == `CMD_CLR_INHIBIT)
    & (pwdata[7:0] == `DATA_CLR_INHIBIT);

  // ---------------------------------------------------------------
  // Boost overvoltage persistence
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !f_q.boostOv || state_q == ST_OFF)
      boostCnt_q <= 12'h000;
    else if (!boostPersist)
      boostCnt_q <= boostCnt_q + 12'h001;
  end
  assign boostPersist = (boostCnt_q >= 12'(`BOOST_OV_CYC - 1));

  // ---------------------------------------------------------------
  // Global OFF conditions with cause vector
  // ---------------------------------------------------------------
  always_comb
  begin
    offCauses = '0;
    offCauses[`CAUSE_BOOST_OV] = boostPersist;
    offCauses[`CAUSE_VREG_UV] = f_q.vregUv;
    offCauses[`CAUSE_VREG_OV] = f_q.vregOv;
    offCauses[`CAUSE_DEV_ERR] = f_q.devErrDown;
    offCauses[`CAUSE_RST_TO] = f_q.resetTimeout;
    offCauses[`CAUSE_EEPROM] = f_q.eepromCrcErr;
    if (isOperating(state_q))
    begin
      offCauses[`CAUSE_CLK] = f_q.clockFault;
      offCauses[`CAUSE_SUPPLY_OVERVOLTAGE_FLAG] = f_q.vinOv;
    end
  end
  assign offCond = (state_q != ST_OFF) && (|offCauses || shutdownCmd);
  assign initFault = f_q.clockFault | f_q.vinOv;
  assign startupTo = (state_q == ST_INIT) && (initTimer_q >= 32'(STARTUP_TO_CYC - 1));

  // ---------------------------------------------------------------
  // Supply check after a filtered wake
  // ---------------------------------------------------------------
  // Rejected wake drops the latch and restarts the filter
  assign wakeReject = (state_q == ST_OFF) && wakeLatch_q
    && (f_q.vinUv || f_q.overTemp);

  // ---------------------------------------------------------------
  // Wake deglitch and wake latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || !wake || state_q != ST_OFF || wakeReject)
      deglitch_q <= 16'h0000;
    else if (lpEn && deglitch_q != 16'(DEGLITCH_CYC))
      deglitch_q <= deglitch_q + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      armed_q <= 1'b1;
    else if (!wake)
      armed_q <= 1'b1;
    else if (offCond && inhibit_q)
      armed_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst || offCond || state_q == ST_INIT || wakeReject)
      wakeLatch_q <= 1'b0;
    else if (state_q == ST_OFF && deglitch_q == 16'(DEGLITCH_CYC) && armed_q)
      wakeLatch_q <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Restart inhibit, held across resets unless battery lost
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!batt)
      inhibit_q <= 1'b0;
    else if (setInhibitCmd || f_q.vregOv)
      inhibit_q <= 1'b1;
    else if (clrInhibitCmd)
      inhibit_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Cause retention latches
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!batt)
      causeLatch_q <= '0;
    else if (offCond)
      causeLatch_q <= causeLatch_q | offCauses;
    else if (startupTo)
      causeLatch_q[`CAUSE_STARTUP_TO] <= 1'b1;
    else if (wakeReject)
    begin
      causeLatch_q[`CAUSE_VIN_UV] <= causeLatch_q[`CAUSE_VIN_UV] | f_q.vinUv;
      causeLatch_q[`CAUSE_OVERTEMP] <= causeLatch_q[`CAUSE_OVERTEMP] | f_q.overTemp;
    end
    else if (copyNow)
      causeLatch_q <= '0;
  end

  // ---------------------------------------------------------------
  // Copy into status after POR release and download
  // ---------------------------------------------------------------
  assign copyNow = (state_q == ST_RESET) && internalPorN && downloadDone && !copied_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      offCause_q <= '0;
    else if (copyNow)
      offCause_q <= causeLatch_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q == ST_OFF)
      copied_q <= 1'b0;
    else if (copyNow)
      copied_q <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Start-up timeout
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || state_q != ST_INIT)
      initTimer_q <= '0;
    else if (!startupTo)
      initTimer_q <= initTimer_q + 32'h1;
  end

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
        if (wakeLatch_q && !f_q.vinUv && !f_q.overTemp)
          state_d = ST_INIT;
      ST_INIT:
        if (startupTo)
          state_d = ST_OFF;
        else if (!initFault)
          state_d = ST_RESET;
      ST_RESET:
        if (!f_q.resetCond && copied_q)
          state_d = f_q.safeCond ? ST_SAFE : ST_DIAG;
      ST_DIAG:
        if (f_q.resetCond)
          state_d = ST_RESET;
        else if (safetyCheck_q[`BIT_LEAVE_DIAG])
          state_d = ST_ACTIVE;
        else if (f_q.safeCond || (f_q.diagDone && !safetyCheck_q[`BIT_DIAG_MASK]))
          state_d = ST_SAFE;
      ST_ACTIVE, ST_SAFE:
        if (f_q.resetCond)
          state_d = ST_RESET;
        else if (f_q.safeCond)
          state_d = ST_SAFE;
      default:
        state_d = ST_OFF;
    endcase
    if (offCond)
      state_d = ST_OFF;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      faultCnt_q <= 4'h0;
    else if (state_q != ST_RESET && state_q != ST_SAFE && state_d == ST_SAFE)
      faultCnt_q <= faultCnt_q + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_q == ST_RESET)
      safetyCheck_q <= 2'b00;
    else if (apbWr && hit(paddr, `ADDR_SAFETY_CHECK))
      safetyCheck_q <= pwdata[1:0];
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      internalPorN <= 1'b0;
    else
      internalPorN <= (state_d != ST_OFF) && !(state_d == ST_INIT && initFault);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      systemResetOutN <= 1'b0;
    else
      systemResetOutN <= (state_d == ST_DIAG) || (state_d == ST_ACTIVE)
        || (state_d == ST_SAFE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      enableDriveIrqOut <= 1'b0;
    else
      enableDriveIrqOut <= (state_d == ST_ACTIVE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      stateOut <= 6'(ST_OFF);
    else
      stateOut <= 6'(state_d);
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      pready <= 1'b0;
    else
      pready <= psel & ~penable;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pslverr <= 1'b0;
    else
      pslverr <= psel & ~penable & ~isMapped(paddr);
  end

  always_ff @(posedge clk)
  begin
    if (rst || !(psel && !penable))
      prdata <= '0;
    else
      case (paddr)
        `ADDR_STATUS: prdata <= {23'h0, inhibit_q, wakeLatch_q, 1'b0, 6'(state_q)};
        `ADDR_OFF_CAUSE: prdata <= {15'h0, offCause_q};
        `ADDR_SAFETY_CHECK: prdata <= {30'h0, safetyCheck_q};
        `ADDR_FAULT_CNT: prdata <= {28'h0, faultCnt_q};
        default: prdata <= '0;
      endcase
  end

endmodule

// ---- mcu_model.sv ----
module mcu_model (
  // Clock and answer
  input wire logic clk,
  input wire logic pready,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // ---
  // Bus cycle
  // ---
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~dt;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] dt);
    xfer(1'b1, 12'h010, {16'h0, c, dt});
  endtask
endmodule

// ---- fsc_sva.sv ----
module fsc_sva
  import failsafe_pkg::*;
#(
  parameter int STARTUP_TO_CYC = 20000
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire fault_in_t faultIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // Outputs
  input wire logic pready,
  input wire logic pslverr,
  input wire logic internalPorN,
  input wire logic systemResetOutN,
  input wire logic enableDriveIrqOut,
  input wire logic [5:0] stateOut
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // ---
  // Cycles spent in start-up
  // ---
  logic [15:0] initCnt_q;
  always_ff @(posedge clk)
  begin
    if (rst || stateOut != ST_INIT)
      initCnt_q <= 16'h0;
    else
      initCnt_q <= initCnt_q + 16'h1;
  end
  property p_off_out;
    (stateOut == ST_OFF) [*2] |-> !(systemResetOutN || enableDriveIrqOut || internalPorN);
  endproperty
  a_off_out: assert property (p_off_out) else $error("outputs on in off");
  property p_hot;
    !$past(rst) |-> $onehot(stateOut);
  endproperty
  a_hot: assert property (p_hot) else $error("state not one-hot");
  property p_init_from;
    $rose(stateOut == ST_INIT) |-> $past(stateOut) == ST_OFF;
  endproperty
  a_init_from: assert property (p_init_from) else $error("init not from off");
  property p_init_max;
    initCnt_q <= STARTUP_TO_CYC + 8;
  endproperty
  a_init_max: assert property (p_init_max) else $error("init too long");
  property p_init_min;
    stateOut == ST_INIT ##1 stateOut == ST_OFF |-> initCnt_q >= STARTUP_TO_CYC - 2;
  endproperty
  a_init_min: assert property (p_init_min) else $error("init left early");
  property p_init_fault;
    faultIn.clockFault [*4] ##0 stateOut == ST_INIT |-> !internalPorN;
  endproperty
  a_init_fault: assert property (p_init_fault) else $error("por released");
  property p_to_reset;
    stateOut == ST_INIT ##1 stateOut == ST_RESET |-> internalPorN;
  endproperty
  a_to_reset: assert property (p_to_reset) else $error("reset with por");
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmapped;
    psel && !penable && !pwrite && paddr == 12'h020 |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  c_active: cover property (stateOut == ST_ACTIVE);
  c_init_off: cover property (stateOut == ST_INIT ##1 stateOut == ST_OFF);
  c_err: cover property (pslverr);
endmodule
bind failsafe_off_init_controller fsc_sva #(.STARTUP_TO_CYC(STARTUP_TO_CYC)) u_sva (
  .clk(clk), .rst(rst), .faultIn(faultIn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .internalPorN(internalPorN),
  .systemResetOutN(systemResetOutN), .enableDriveIrqOut(enableDriveIrqOut),
  .stateOut(stateOut));

// ---- failsafe_off_init_controller_tb_top.sv ----
module failsafe_off_init_controller_tb_top
  import failsafe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic batteryPresent = 1'b0;
  logic wakePin = 1'b0;
  logic lpTick = 1'b0;
  logic downloadDone = 1'b0;
  fault_in_t faultIn = '0;
  logic psel, penable, pwrite, pready, pslverr, internalPorN, systemResetOutN, enableDriveIrqOut;
  logic [2:0] lpCnt = 3'h0;
  logic [5:0] stateOut;
  logic [7:0] d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [31:0] expQ[$], mskQ[$];
  logic [16:0] cmdT[4] = '{17'h101aa, 17'h10256, 17'h00255, 17'h101aa};
  string nmQ[$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    lpCnt <= lpCnt + 3'h1;
    lpTick <= lpCnt[2];
  end
  failsafe_off_init_controller #(.STARTUP_TO_CYC(50), .DEGLITCH_CYC(4)) dut (
    .clk(clk), .rst(rst), .batteryPresent(batteryPresent), .wakePin(wakePin), .lpTick(lpTick),
    .faultIn(faultIn), .downloadDone(downloadDone), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internalPorN(internalPorN), .systemResetOutN(systemResetOutN),
    .enableDriveIrqOut(enableDriveIrqOut), .stateOut(stateOut));
  mcu_model u_mcu (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ---
  // Checking
  // ---
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
      check(nmQ.pop_front(), prdata & mskQ.pop_front(), expQ.pop_front());
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] e);
    nmQ.push_back(nm);
    mskQ.push_back(m);
    expQ.push_back(e);
    u_mcu.xfer(1'b0, a, 32'h0);
  endtask
  task automatic waitst(input logic [5:0] s, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (stateOut !== s && n < lim);
    check("state", 32'(stateOut), 32'(s));
  endtask
  task automatic rewake();
    wakePin <= 1'b0;
    repeat (60) @(posedge clk);
    wakePin <= 1'b1;
    waitst(ST_INIT, 300);
    waitst(ST_RESET, 100);
    waitst(ST_DIAG, 300);
  endtask
  // ---
  // Scenarios
  // ---
  initial
  begin
    void'($urandom(10343));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    batteryPresent <= 1'b1;
    downloadDone <= 1'b1;
    rd("unmapped", 12'h020, 32'h0, 32'h0);
    faultIn.vinUv <= 1'b1;
    wakePin <= 1'b1;
    repeat (200) @(posedge clk);
    check("uv wake", 32'(stateOut), 32'(ST_OFF));
    wakePin <= 1'b0;
    repeat (4) @(posedge clk);
    faultIn.vinUv <= 1'b0;
    rewake();
    rd("cause", 12'h008, 32'h1ffff, 32'h1);
    rd("status", 12'h004, 32'h13f, 32'h8);
    repeat (3)
    begin
      d = 8'($urandom);
      if (d == 8'haa)
        d = 8'h0;
      u_mcu.cmd(8'h01, d);
      rd("inhibit", 12'h004, 32'h100, 32'h0);
    end
    foreach (cmdT[i])
    begin
      u_mcu.cmd(cmdT[i][15:8], cmdT[i][7:0]);
      rd("inhibit", 12'h004, 32'h100, {15'h0, cmdT[i][16], 16'h0} >> 8);
    end
    u_mcu.xfer(1'b1, 12'h00c, 32'h1);
    waitst(ST_ACTIVE, 20);
    repeat (2) @(posedge clk);
    check("enable", 32'(enableDriveIrqOut), 32'h1);
    faultIn.boostOv <= 1'b1;
    waitst(ST_OFF, 4100);
    check("boost time", 32'(n >= 3600 && n <= 4002), 32'h1);
    faultIn.boostOv <= 1'b0;
    repeat (200) @(posedge clk);
    check("no restart", 32'(stateOut), 32'(ST_OFF));
    rewake();
    rd("cause", 12'h008, 32'h1ffff, 32'h800);
    rd("inhibit", 12'h004, 32'h100, 32'h100);
    u_mcu.cmd(8'h02, 8'h55);
    u_mcu.cmd(8'h03, 8'($urandom));
    waitst(ST_OFF, 20);
    check("off outs", 32'({systemResetOutN, enableDriveIrqOut}), 32'h0);
    faultIn.clockFault <= 1'b1;
    waitst(ST_INIT, 300);
    waitst(ST_OFF, 100);
    faultIn.clockFault <= 1'b0;
    rewake();
    rd("cause", 12'h008, 32'h1ffff, 32'h10000);
    faultIn.clockFault <= 1'b1;
    waitst(ST_OFF, 20);
    faultIn.clockFault <= 1'b0;
    rewake();
    rd("cause", 12'h008, 32'h1ffff, 32'h2);
    faultIn.resetCond <= 1'b1;
    faultIn.safeCond <= 1'b1;
    waitst(ST_RESET, 20);
    repeat (5) @(posedge clk);
    check("hold reset", 32'(stateOut), 32'(ST_RESET));
    faultIn.resetCond <= 1'b0;
    waitst(ST_SAFE, 20);
    rd("fault count", 12'h014, 32'hf, 32'h0);
    give_verdict();
  end
endmodule
